// ### rtl/line_maintenance_pattern_loopback.v
`timescale 1ns/10ps
`default_nettype none

// Operation
// - Alarm detection runs only with clock recovery enabled; result readable as status.
// - E1 default criteria: two consecutive 512-bit blocks under 3 zeros declare alarm.
// - E1 alternate criteria: one 512-bit block decides, threshold 3 zeros.
// - T1/J1: 8192-bit block with fewer than 9 zeros declares, 9 clears.
// - Patterns run on transmit clock, or on master clock when clock select set.
// - Source 00 with transmit clock passes system data and stops code sending.
// - Source 01 sends all ones on the selected pattern clock.
// - Master clock selected with source 00 sends all zeros.
// - Sequence is 2^20-1 quasi-random, zero-limited, in T1/J1, 2^15-1 in E1.
// - Source 10 sends the sequence first bit first, inverted on request.
// - Lock set at six or fewer errors in 64 bits, cleared above six.
// - Lock changes set a sticky event, edge mode chosen, alert when enabled.
// - Error type 00 counts sequence errors in the 16-bit counter.
// - Analog loop returns transmit stream to receive outputs, line still driven.
// - Digital loop by bit or pins 10 returns transmit data, line still driven.
// - Internal patterns replace transmit data during analog or digital loop.
// - Remote loop by bit or pins 11 sends recovered data back to line.
// - Source 11 repeats the unframed programmed loop code toward the line.
// - Receiver spots loop codes framed or unframed despite occasional bit errors.
// - Auto loop sets remote loop after 5.1 s activate code, clears likewise.
// - Loop code is 8-bit pattern, 5 to 8 bits long by 2-bit field.

`include "lmpl_consts.vh"

module line_maintenance_pattern_loopback #(
  parameter        MCLK_DIV         = `LMPL_MCLK_DIV,
  parameter [27:0] AUTO_LOOP_CYCLES = `LMPL_AUTO_LOOP_CYC
) (
  input  wire        i_clk,
  input  wire        i_reset,
  input  wire        i_wb_cyc,
  input  wire        i_wb_stb,
  input  wire        i_wb_we,
  input  wire [7:0]  i_wb_adr,
  input  wire [3:0]  i_wb_sel,
  input  wire [31:0] i_wb_dat,
  output reg  [31:0] o_wb_dat,
  output reg         o_wb_ack,
  input  wire        i_tx_clock_in,
  input  wire        i_tx_data,
  input  wire        i_rx_clock,
  input  wire        i_rx_data,
  input  wire [1:0]  i_tx_source_select,
  input  wire [1:0]  i_loop_select_pins,
  output reg         o_line_tx_tip,
  output reg         o_line_tx_ring,
  output reg         o_line_tx_strobe,
  output reg         o_rx_data,
  output reg         o_rx_strobe,
  output wire        o_seq_lock_alert
);

  // ****************************************************************
  // Pin synchronisers: three stages, a value is taken once the last two agree.
  // ****************************************************************
  wire [7:0] pin_raw;
  reg  [7:0] s1_q;
  reg  [7:0] s2_q;
  reg  [7:0] s3_q;
  reg  [7:0] pin_q;
  reg  [7:0] pin_prev_q;

  assign pin_raw = {i_loop_select_pins, i_tx_source_select, i_rx_data, i_rx_clock,
                    i_tx_data, i_tx_clock_in};

  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1) begin : g_sync
      always @(posedge i_clk) begin
        if (i_reset) begin
          s1_q[g]       <= 1'b0;
          s2_q[g]       <= 1'b0;
          s3_q[g]       <= 1'b0;
          pin_q[g]      <= 1'b0;
          pin_prev_q[g] <= 1'b0;
        end else begin
          s1_q[g]       <= pin_raw[g];
          s2_q[g]       <= s1_q[g];
          s3_q[g]       <= s2_q[g];
          if (s2_q[g] == s3_q[g]) begin
            pin_q[g] <= s3_q[g];
          end
          pin_prev_q[g] <= pin_q[g];
        end
      end
    end
  endgenerate

  wire tx_clock_in_tick = pin_q[0] & ~pin_prev_q[0];
  wire rclk_tick = pin_q[2] & ~pin_prev_q[2];

  // ****************************************************************
  // Control registers.
  // ****************************************************************
  reg  [7:0]  ctrl_q;
  reg  [3:0]  loop_q;
  reg  [9:0]  txcode_q;
  reg  [25:0] rxcode_q;
  reg  [1:0]  evt_cfg_q;
  reg  [1:0]  err_sel_q;
  reg  [15:0] err_cnt_q;
  reg         lock_event_q;
  reg         alarm_q;
  reg         remote_auto_q;
  reg         act_seen_q;
  reg         deact_seen_q;
  wire        seq_lock_status;

  wire       hw_mode             = ctrl_q[`LMPL_CTRL_HW];
  wire       source_clock_select = ctrl_q[`LMPL_CTRL_CLKSEL];
  wire       seq_invert          = ctrl_q[`LMPL_CTRL_INV];
  wire       criteria_select     = ctrl_q[`LMPL_CTRL_CRIT];
  wire       t1_mode             = ctrl_q[`LMPL_CTRL_T1];
  wire       cdr_enable          = ctrl_q[`LMPL_CTRL_CDR];
  wire [1:0] tx_source_select    = hw_mode ? pin_q[5:4] : ctrl_q[1:0];
  wire       analog_loop         = loop_q[0];
  wire       digital_loop        = loop_q[1] | (hw_mode & (pin_q[7:6] == 2'b10));
  wire       remote_loop         = loop_q[2] | (hw_mode & (pin_q[7:6] == 2'b11))
                                   | remote_auto_q;
  wire       auto_remote_enable  = loop_q[3];

  wire bus_req  = i_wb_cyc & i_wb_stb & ~o_wb_ack;
  wire bus_wr   = bus_req & i_wb_we;
  wire evt_wclr = bus_wr & (i_wb_adr == `LMPL_REG_EVENT) & i_wb_sel[0] & i_wb_dat[0];

  always @(posedge i_clk) begin
    if (i_reset) begin
      ctrl_q    <= `LMPL_CTRL_RESET;
      loop_q    <= 4'h0;
      txcode_q  <= 10'h000;
      rxcode_q  <= 26'h000_0000;
      evt_cfg_q <= 2'b00;
      err_sel_q <= 2'b00;
      o_wb_ack  <= 1'b0;
      o_wb_dat  <= 32'h0000_0000;
    end else begin
      o_wb_ack <= bus_req;
      if (bus_wr) begin
        case (i_wb_adr)
          `LMPL_REG_CTRL: begin
            if (i_wb_sel[0]) ctrl_q <= i_wb_dat[7:0];
          end
          `LMPL_REG_LOOP: begin
            if (i_wb_sel[0]) loop_q <= i_wb_dat[3:0];
          end
          `LMPL_REG_TXCODE: begin
            if (i_wb_sel[0]) txcode_q[7:0] <= i_wb_dat[7:0];
            if (i_wb_sel[1]) txcode_q[9:8] <= i_wb_dat[9:8];
          end
          `LMPL_REG_RXCODE: begin
            if (i_wb_sel[0]) rxcode_q[7:0]   <= i_wb_dat[7:0];
            if (i_wb_sel[1]) rxcode_q[9:8]   <= i_wb_dat[9:8];
            if (i_wb_sel[2]) rxcode_q[23:16] <= i_wb_dat[23:16];
            if (i_wb_sel[3]) rxcode_q[25:24] <= i_wb_dat[25:24];
          end
          `LMPL_REG_EVENT: begin
            if (i_wb_sel[1]) evt_cfg_q <= i_wb_dat[9:8];
          end
          `LMPL_REG_ERRCNT: begin
            if (i_wb_sel[2]) err_sel_q <= i_wb_dat[17:16];
          end
          default: begin
          end
        endcase
      end
      // Read data is only refreshed when a request is taken, so it stands until the next one.
      if (bus_req) begin
      case (i_wb_adr)
        `LMPL_REG_CTRL:   o_wb_dat <= {24'h00_0000, ctrl_q};
        `LMPL_REG_LOOP:   o_wb_dat <= {28'h000_0000, loop_q};
        `LMPL_REG_TXCODE: o_wb_dat <= {22'h00_0000, txcode_q};
        `LMPL_REG_RXCODE: o_wb_dat <= {6'h00, rxcode_q};
        `LMPL_REG_STATUS: o_wb_dat <= {27'h000_0000, deact_seen_q, act_seen_q, remote_loop,
                                       seq_lock_status, alarm_q};
        `LMPL_REG_EVENT:  o_wb_dat <= {22'h00_0000, evt_cfg_q, 7'h00, lock_event_q};
        `LMPL_REG_ERRCNT: o_wb_dat <= {14'h0000, err_sel_q, err_cnt_q};
        default:          o_wb_dat <= 32'h0000_0000;
      endcase
      end
    end
  end

  // ****************************************************************
  // Pattern clock selection.
  // ****************************************************************
  reg  [7:0] mdiv_q;
  wire       mclk_tick = (mdiv_q == 8'd0);

  always @(posedge i_clk) begin
    if (i_reset) begin
      mdiv_q <= 8'd0;
    end else if (mclk_tick) begin
      mdiv_q <= MCLK_DIV[7:0] - 8'd1;
    end else begin
      mdiv_q <= mdiv_q - 8'd1;
    end
  end

  wire pat_tick = source_clock_select ? mclk_tick : tx_clock_in_tick;

  // ****************************************************************
  // Sequence generator: 20-bit register, short taps in E1.
  // ****************************************************************
  reg  [19:0] gen_q;
  wire        gen_fb  = t1_mode ? (gen_q[19] ^ gen_q[16]) : (gen_q[14] ^ gen_q[13]);
  wire        gen_lim = t1_mode & (gen_q[13:0] == 14'h0000);
  wire        gen_bit = (gen_lim ? 1'b1 : gen_fb) ^ seq_invert;

  always @(posedge i_clk) begin
    if (i_reset) begin
      gen_q <= 20'h0_0001;
    end else if (pat_tick) begin
      gen_q <= {gen_q[18:0], gen_fb | (gen_q == 20'h0_0000)};
    end
  end

  // ****************************************************************
  // Transmit loop code, length 5 to 8 bits, sent first bit first.
  // ****************************************************************
  reg  [2:0] code_idx_q;
  wire [2:0] tx_code_last = {1'b1, txcode_q[9:8]};
  wire [2:0] tx_code_pos  = tx_code_last - code_idx_q;
  wire       code_bit     = txcode_q[tx_code_pos];

  always @(posedge i_clk) begin
    if (i_reset || tx_source_select != 2'b11) begin
      code_idx_q <= 3'd0;
    end else if (pat_tick) begin
      code_idx_q <= (code_idx_q == tx_code_last) ? 3'd0 : code_idx_q + 3'd1;
    end
  end

  // ****************************************************************
  // Transmit source and loopback routing.
  // ****************************************************************
  reg  tx_bit;
  wire tx_tick = remote_loop ? rclk_tick : pat_tick;

  always @* begin
    case (tx_source_select)
      2'b00:   tx_bit = source_clock_select ? 1'b0 : pin_q[1];
      2'b01:   tx_bit = 1'b1;
      2'b10:   tx_bit = gen_bit;
      2'b11:   tx_bit = code_bit;
      default: tx_bit = 1'b0;
    endcase
  end

  wire line_bit = remote_loop ? pin_q[3] : tx_bit;
  reg  ami_pol_q;

  always @(posedge i_clk) begin
    if (i_reset) begin
      o_line_tx_tip    <= 1'b0;
      o_line_tx_ring   <= 1'b0;
      o_line_tx_strobe <= 1'b0;
      ami_pol_q        <= 1'b0;
    end else begin
      o_line_tx_strobe <= tx_tick;
      if (tx_tick) begin
        // The line still carries the stream during analog and digital loops.
        o_line_tx_tip  <= line_bit & ~ami_pol_q;
        o_line_tx_ring <= line_bit & ami_pol_q;
        ami_pol_q      <= ami_pol_q ^ line_bit;
      end
    end
  end

  // ****************************************************************
  // Receive stream: recovered data, or the transmit stream in local loops.
  // ****************************************************************
  wire local_loop = analog_loop | digital_loop;
  wire rx_tick    = local_loop ? pat_tick : rclk_tick;
  wire rx_bit     = local_loop ? tx_bit : pin_q[3];

  always @(posedge i_clk) begin
    if (i_reset) begin
      o_rx_data   <= 1'b0;
      o_rx_strobe <= 1'b0;
    end else begin
      o_rx_strobe <= rx_tick;
      if (rx_tick) begin
        o_rx_data <= rx_bit;
      end
    end
  end

  // ****************************************************************
  // Alarm indication detection.
  // ****************************************************************
  reg  [12:0] blk_cnt_q;
  reg  [3:0]  zero_cnt_q;
  reg         prev_low_q;
  wire [13:0] blk_span = t1_mode ? `LMPL_T1_BLOCK_BITS : `LMPL_E1_BLOCK_BITS;
  wire [13:0] blk_span_m1 = blk_span - 14'd1;
  wire [12:0] blk_last = blk_span_m1[12:0];
  wire [3:0]  min_zero = t1_mode ? `LMPL_T1_MIN_ZEROS : `LMPL_E1_MIN_ZEROS;
  wire [3:0]  zeros_d  = zero_cnt_q + {3'd0, (~rx_bit & (zero_cnt_q != 4'hF))};
  wire        blk_low  = zeros_d < min_zero;
  wire        one_blk  = t1_mode | criteria_select;

  always @(posedge i_clk) begin
    if (i_reset || !cdr_enable) begin
      blk_cnt_q  <= 13'd0;
      zero_cnt_q <= 4'd0;
      prev_low_q <= 1'b0;
      alarm_q    <= 1'b0;
    end else if (rx_tick) begin
      if (blk_cnt_q == blk_last) begin
        blk_cnt_q  <= 13'd0;
        zero_cnt_q <= 4'd0;
        prev_low_q <= blk_low;
        if (one_blk) begin
          alarm_q <= blk_low;
        end else if (blk_low && prev_low_q) begin
          alarm_q <= 1'b1;
        end else if (!blk_low && !prev_low_q) begin
          alarm_q <= 1'b0;
        end
      end else begin
        blk_cnt_q  <= blk_cnt_q + 13'd1;
        zero_cnt_q <= zeros_d;
      end
    end
  end

  // ****************************************************************
  // Sequence checker, lock window, events and error counting.
  // ****************************************************************
  reg  [19:0] chk_q;
  wire        rx_plain = rx_bit ^ seq_invert;
  wire        chk_fb   = t1_mode ? (chk_q[19] ^ chk_q[16]) : (chk_q[14] ^ chk_q[13]);
  wire        chk_lim  = t1_mode & (chk_q[13:0] == 14'h0000);
  wire        seq_err  = rx_tick & ~chk_lim & (chk_fb != rx_plain);
  reg         lock_prev_q;

  always @(posedge i_clk) begin
    if (i_reset) begin
      chk_q <= 20'h0_0000;
    end else if (rx_tick) begin
      chk_q <= {chk_q[18:0], rx_plain};
    end
  end

  seq_lock_checker #(
    .WINDOW (`LMPL_LOCK_WINDOW)
  ) u_lock (
    .i_clk   (i_clk),
    .i_reset (i_reset),
    .i_tick  (rx_tick),
    .i_error (seq_err),
    .o_lock  (seq_lock_status)
  );

  wire lock_change = (seq_lock_status != lock_prev_q) &
                     (evt_cfg_q[0] | seq_lock_status);

  always @(posedge i_clk) begin
    if (i_reset) begin
      lock_prev_q  <= 1'b0;
      lock_event_q <= 1'b0;
      err_cnt_q    <= 16'h0000;
    end else begin
      lock_prev_q <= seq_lock_status;
      if (lock_change) begin
        lock_event_q <= 1'b1;
      end else if (evt_wclr) begin
        lock_event_q <= 1'b0;
      end
      if (seq_err && err_sel_q == 2'b00 && err_cnt_q != 16'hFFFF) begin
        err_cnt_q <= err_cnt_q + 16'h0001;
      end else if (bus_wr && i_wb_adr == `LMPL_REG_ERRCNT && i_wb_sel[0]) begin
        err_cnt_q <= 16'h0000;
      end
    end
  end

  assign o_seq_lock_alert = lock_event_q & evt_cfg_q[1];

  // ****************************************************************
  // Receive loop code detection and automatic remote loop.
  // ****************************************************************
  reg  [7:0]  rx_hist_q;
  reg  [7:0]  win_cnt_q;
  reg  [7:0]  act_hits_q;
  reg  [7:0]  deact_hits_q;
  reg  [27:0] act_tmr_q;
  reg  [27:0] deact_tmr_q;

  function match_code;
    input [7:0] hist;
    input [7:0] code;
    input [1:0] len;
    reg   [7:0] mask;
    begin
      mask       = 8'hFF >> (2'd3 - len);
      match_code = ((hist ^ code) & mask) == 8'h00;
    end
  endfunction

  wire act_hit   = match_code(rx_hist_q, rxcode_q[7:0], rxcode_q[9:8]);
  wire deact_hit = match_code(rx_hist_q, rxcode_q[23:16], rxcode_q[25:24]);

  always @(posedge i_clk) begin
    if (i_reset) begin
      rx_hist_q    <= 8'h00;
      win_cnt_q    <= 8'h00;
      act_hits_q   <= 8'h00;
      deact_hits_q <= 8'h00;
      act_seen_q   <= 1'b0;
      deact_seen_q <= 1'b0;
    end else if (rx_tick) begin
      rx_hist_q <= {rx_hist_q[6:0], rx_bit};
      win_cnt_q <= win_cnt_q + 8'h01;
      if (win_cnt_q == `LMPL_CODE_WIN_BITS) begin
        // Counting hits over a window rides over framing bits and bit errors.
        act_seen_q   <= act_hits_q >= `LMPL_CODE_MIN_HITS;
        deact_seen_q <= deact_hits_q >= `LMPL_CODE_MIN_HITS;
        act_hits_q   <= 8'h00;
        deact_hits_q <= 8'h00;
      end else begin
        act_hits_q   <= act_hits_q + {7'd0, act_hit & (act_hits_q != 8'hFF)};
        deact_hits_q <= deact_hits_q + {7'd0, deact_hit & (deact_hits_q != 8'hFF)};
      end
    end
  end

  always @(posedge i_clk) begin
    if (i_reset || !auto_remote_enable) begin
      act_tmr_q     <= 28'd0;
      deact_tmr_q   <= 28'd0;
      remote_auto_q <= 1'b0;
    end else begin
      act_tmr_q   <= act_seen_q ? ((act_tmr_q == AUTO_LOOP_CYCLES) ? act_tmr_q
                                   : act_tmr_q + 28'd1) : 28'd0;
      deact_tmr_q <= deact_seen_q ? ((deact_tmr_q == AUTO_LOOP_CYCLES) ? deact_tmr_q
                                     : deact_tmr_q + 28'd1) : 28'd0;
      if (deact_tmr_q == AUTO_LOOP_CYCLES) begin
        remote_auto_q <= 1'b0;
      end else if (act_tmr_q == AUTO_LOOP_CYCLES) begin
        remote_auto_q <= 1'b1;
      end
    end
  end

endmodule

`default_nettype wire

// ### shared/lmpl_consts.vh
`ifndef LMPL_CONSTS_VH
`define LMPL_CONSTS_VH

// ****************************************************************
// Register byte offsets.
// ****************************************************************
`define LMPL_REG_CTRL      8'h00
`define LMPL_REG_LOOP      8'h04
`define LMPL_REG_TXCODE    8'h08
`define LMPL_REG_RXCODE    8'h0C
`define LMPL_REG_STATUS    8'h10
`define LMPL_REG_EVENT     8'h14
`define LMPL_REG_ERRCNT    8'h18

// ****************************************************************
// Field positions.
// ****************************************************************
`define LMPL_CTRL_SRC_LO   0
`define LMPL_CTRL_CLKSEL   2
`define LMPL_CTRL_INV      3
`define LMPL_CTRL_CRIT     4
`define LMPL_CTRL_T1       5
`define LMPL_CTRL_CDR      6
`define LMPL_CTRL_HW       7
`define LMPL_EVT_EDGE      8
`define LMPL_EVT_EN        9
`define LMPL_ERR_SEL_LO    16

// ****************************************************************
// Reset values.
// ****************************************************************
`define LMPL_CTRL_RESET    8'h40
`define LMPL_CODE_RESET    8'h00

// ****************************************************************
// Alarm detection criteria.
// ****************************************************************
`define LMPL_E1_BLOCK_BITS 14'd512
`define LMPL_T1_BLOCK_BITS 14'd8192
`define LMPL_E1_MIN_ZEROS  4'd3
`define LMPL_T1_MIN_ZEROS  4'd9

// ****************************************************************
// Sequence lock window.
// ****************************************************************
`define LMPL_LOCK_WINDOW   64
`define LMPL_LOCK_MAX_ERR  7'd6

// ****************************************************************
// Loop code detection and timing.
// ****************************************************************
`define LMPL_CODE_WIN_BITS 8'd255
`define LMPL_CODE_MIN_HITS 8'd16
`define LMPL_AUTO_LOOP_MS  5100
`define LMPL_CLK_KHZ       40000
`define LMPL_AUTO_LOOP_CYC (`LMPL_AUTO_LOOP_MS * `LMPL_CLK_KHZ)
`define LMPL_MCLK_DIV      20

`endif

// ### rtl/seq_lock_checker.v
`timescale 1ns/10ps
`default_nettype none

// ****************************************************************
// Sliding-window error monitor for the sequence checker.
// ****************************************************************
`include "lmpl_consts.vh"

module seq_lock_checker #(
  parameter WINDOW = `LMPL_LOCK_WINDOW
) (
  input  wire       i_clk,
  input  wire       i_reset,
  input  wire       i_tick,
  input  wire       i_error,
  output reg        o_lock
);

  reg  [WINDOW-1:0] hist_q;
  reg  [6:0]        count_q;
  wire [6:0]        count_d;

  // The count tracks the errors held in the window as bits enter and leave.
  assign count_d = count_q + {6'd0, i_error} - {6'd0, hist_q[WINDOW-1]};

  always @(posedge i_clk) begin
    if (i_reset) begin
      hist_q  <= {WINDOW{1'b0}};
      count_q <= 7'd0;
      o_lock  <= 1'b0;
    end else if (i_tick) begin
      hist_q  <= {hist_q[WINDOW-2:0], i_error};
      count_q <= count_d;
      o_lock  <= (count_d <= `LMPL_LOCK_MAX_ERR);
    end
  end

endmodule

`default_nettype wire

// ### bench/lmpl_sva.sv
`timescale 1ns/10ps
`default_nettype none
module lmpl_sva (
  input wire logic        i_clk,
  input wire logic        i_reset,
  input wire logic        i_wb_cyc,
  input wire logic        i_wb_stb,
  input wire logic [31:0] o_wb_dat,
  input wire logic        o_wb_ack,
  input wire logic        o_line_tx_tip,
  input wire logic        o_line_tx_ring,
  input wire logic        o_line_tx_strobe,
  input wire logic        o_rx_data,
  input wire logic        o_rx_strobe,
  input wire logic        o_seq_lock_alert
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_reset);
  a_ack_one_cycle: assert property (o_wb_ack |=> !o_wb_ack) else $error("long ack");
  a_ack_on_take: assert property (i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack)
    else $error("no ack");
  a_ack_needs_req: assert property (!(i_wb_cyc && i_wb_stb) |=> !o_wb_ack)
    else $error("stray ack");
  a_rdata_holds: assert property (!(i_wb_cyc && i_wb_stb) |=> $stable(o_wb_dat))
    else $error("read data moved");
  a_reset_quiet:
    assert property ($fell(i_reset) |-> !(o_wb_ack | o_line_tx_strobe | o_rx_strobe))
    else $error("busy after reset");
  a_rail_exclusive:
    assert property (!(o_line_tx_tip && o_line_tx_ring)) else $error("both rails");
  a_tx_bit_gap:
    assert property (disable iff (i_reset || o_wb_ack)
      o_line_tx_strobe |=> !o_line_tx_strobe [*3]) else $error("tx bits close");
  a_rx_bit_gap:
    assert property (disable iff (i_reset || o_wb_ack)
      o_rx_strobe |=> !o_rx_strobe [*3]) else $error("rx bits close");
  c_lock_alert: cover property (o_seq_lock_alert);
  c_tx_mark: cover property (o_line_tx_strobe && o_line_tx_tip);
  c_rx_one: cover property (o_rx_strobe && o_rx_data);
endmodule
bind line_maintenance_pattern_loopback lmpl_sva lmpl_sva_i (.i_clk, .i_reset, .i_wb_cyc,
  .i_wb_stb, .o_wb_dat, .o_wb_ack, .o_line_tx_tip, .o_line_tx_ring, .o_line_tx_strobe,
  .o_rx_data, .o_rx_strobe, .o_seq_lock_alert);
`default_nettype wire

// ### bench/far_end_line.sv
`timescale 1ns/10ps
`default_nettype none
module far_end_line #(
  parameter int LAG = 2
) (
  input  wire logic i_clk,
  input  wire logic i_invert,
  input  wire logic i_tip,
  input  wire logic i_ring,
  input  wire logic i_strobe,
  output var logic  o_rx_clock,
  output var logic  o_rx_data
);
  // Echoes each strobed line bit, mark or space, as one received bit; the data line toggles between bits.
  logic [3:0] age_q = '0;
  logic       bit_q = '0;
  initial o_rx_clock = '0;
  initial o_rx_data = '0;
  always @(posedge i_clk) begin
    if (i_strobe) begin
      bit_q <= (i_tip | i_ring) ^ i_invert;
      age_q <= 4'h1;
    end else if (age_q != 4'h0) begin
      age_q <= age_q + 4'h1;
    end
    o_rx_clock <= age_q > LAG && age_q < LAG + 5;
    o_rx_data  <= (age_q >= LAG && age_q < LAG + 6) ? bit_q : ~o_rx_data;
  end
endmodule
`default_nettype wire

// ### bench/line_maintenance_pattern_loopback_bench.sv
`timescale 1ns/10ps
`default_nettype none
`include "lmpl_consts.vh"
`define CHK(nm, got, exp) begin n_checks++; if ((got) !== (exp)) begin err_total++; \
  $display("Error %s expected %0h seen %0h", nm, exp, got); end end
module line_maintenance_pattern_loopback_bench;
  localparam logic [7:0] ctl = `LMPL_REG_CTRL, lpr = `LMPL_REG_LOOP, sts = `LMPL_REG_STATUS;
  localparam logic [7:0] evt = `LMPL_REG_EVENT;
  logic        clk = '0, rst = '1, cyc = '0, stb = '0, we = '0, txc = '0, txd = '0, trun = '1;
  logic        inv = '0, ack, rxc, rxd, tip, ring, ts, rxo, rxs, alert;
  logic [1:0]  tq = '0, srcp = '0, lpp = '0;
  logic [7:0]  adr = '0;
  logic [31:0] wd = '0, rdat, rd;
  int          err_total = 0, n_checks = 0, n_tx, n_mk, n_rx, n_r1;
  always #12.5 clk = ~clk;
  always @(posedge clk) if (trun) {txc, tq} <= {txc, tq} + 3'h1;
  always @(posedge clk) begin
    if (ts === 1'b1) begin
      n_tx++;
      n_mk += int'(tip | ring);
    end
    if (rxs === 1'b1) begin
      n_rx++;
      n_r1 += int'(rxo);
    end
  end
  line_maintenance_pattern_loopback #(.MCLK_DIV(8), .AUTO_LOOP_CYCLES(28'h7D0))
    line_maintenance_pattern_loopback_i (.i_clk(clk), .i_reset(rst), .i_wb_cyc(cyc),
    .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(4'hF), .i_wb_dat(wd),
    .o_wb_dat(rdat), .o_wb_ack(ack), .i_tx_clock_in(txc), .i_tx_data(txd),
    .i_rx_clock(rxc), .i_rx_data(rxd), .i_tx_source_select(srcp),
    .i_loop_select_pins(lpp), .o_line_tx_tip(tip), .o_line_tx_ring(ring),
    .o_line_tx_strobe(ts), .o_rx_data(rxo), .o_rx_strobe(rxs), .o_seq_lock_alert(alert));
  far_end_line far_end_line_i (.i_clk(clk), .i_invert(inv), .i_tip(tip), .i_ring(ring),
    .i_strobe(ts), .o_rx_clock(rxc), .o_rx_data(rxd));
  task automatic report_and_stop;
    $display("Checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge clk);
    {cyc, stb, we, adr, wd} <= {2'h3, w, a, d};
    for (i = 0; i < 40; i++) begin
      @(posedge clk);
      if (ack === 1'b1) break;
    end
    rd = rdat;
    {cyc, stb} <= 2'h0;
    if (i == 40) begin
      err_total++;
      report_and_stop();
    end
  endtask
  task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] m, e);
    wb(0, a, 0);
    `CHK(nm, rd & m, e)
  endtask
  task automatic meas(input int n);
    repeat (40) @(posedge clk);
    #1 {n_tx, n_mk, n_rx, n_r1} = '0;
    for (int i = 0; i < 20 * n && n_tx < n; i++) @(negedge clk);
    `CHK("bits", n_tx, n)
  endtask
  task automatic poll(input int b, input logic v);
    for (int i = 0; i < 5000; i++) begin
      wb(0, sts, 0);
      if (rd[b] === v) break;
    end
    if (rd[b] !== v) begin
      err_total++;
      report_and_stop();
    end
  endtask
  task automatic t_sources;
    rchk("ctrl", ctl, 32'hFF, `LMPL_CTRL_RESET);
    rchk("loop", lpr, 32'hF, 32'h0);
    rchk("hole", 8'h1C, 32'hFFFF_FFFF, 32'h0);
    txd <= 1'b1;
    meas(16);
    `CHK("normal", n_mk, 16)
    wb(1, ctl, 32'h44);
    meas(16);
    `CHK("zeros", n_mk, 0)
    wb(1, ctl, 32'h41);
    meas(16);
    `CHK("ones", n_mk, 16)
    trun <= 1'b0;
    wb(1, ctl, 32'h45);
    meas(16);
    `CHK("master", n_mk, 16)
    trun <= 1'b1;
  endtask
  task automatic t_alarm;
    wb(1, ctl, 32'h44);
    meas(600);
    wb(1, ctl, 32'h45);
    meas(1000);
    rchk("alarm early", sts, 32'h1, 32'h0);
    poll(0, 1'b1);
    rchk("alarm", sts, 32'h1, 32'h1);
    wb(1, ctl, 32'h05);
    rchk("alarm off", sts, 32'h1, 32'h0);
  endtask
  task automatic t_lock;
    wb(1, evt, 32'h201);
    wb(1, ctl, 32'h46);
    poll(1, 1'b1);
    rchk("lock", sts, 32'h2, 32'h2);
    rchk("event", evt, 32'h1, 32'h1);
    `CHK("alert", alert, 1'b1)
    meas(64);
    `CHK("mix", n_mk > 8 && n_mk < 56, 1'b1)
    wb(1, `LMPL_REG_ERRCNT, 32'h0);
    wb(1, evt, 32'h201);
    wb(1, ctl, 32'h45);
    poll(1, 1'b0);
    rchk("unlock", sts, 32'h2, 32'h0);
    rchk("rise only", evt, 32'h1, 32'h0);
    wb(0, `LMPL_REG_ERRCNT, 0);
    `CHK("errors", rd[15:0] != 16'h0, 1'b1)
    wb(1, ctl, 32'h46);
    poll(1, 1'b1);
    wb(1, evt, 32'h301);
    wb(1, ctl, 32'h45);
    poll(1, 1'b0);
    rchk("any edge", evt, 32'h1, 32'h1);
  endtask
  task automatic t_code;
    logic [9:0] c [3] = '{10'h3A5, 10'h010, 10'h107};
    int         o [3] = '{32, 12, 30};
    wb(1, ctl, 32'h47);
    for (int k = 0; k < 3; k++) begin
      wb(1, `LMPL_REG_TXCODE, {22'h0, c[k]});
      meas(k == 0 ? 64 : 60);
      `CHK("code", n_mk, o[k])
    end
    wb(1, `LMPL_REG_TXCODE, 32'h3A5);
    wb(1, `LMPL_REG_RXCODE, 32'h0300_03A5);
    wb(1, lpr, 32'h8);
    rchk("auto early", sts, 32'h4, 32'h0);
    poll(2, 1'b1);
    rchk("auto on", sts, 32'h4, 32'h4);
    wb(1, lpr, 32'h0);
    rchk("auto off", sts, 32'h4, 32'h0);
  endtask
  task automatic t_local;
    logic [7:0] lr [3] = '{8'h2, 8'h1, 8'h0};
    logic [7:0] cr [3] = '{8'h45, 8'h45, 8'hC5};
    {inv, srcp, lpp} <= 5'h16;
    for (int k = 0; k < 3; k++) begin
      wb(1, lpr, {24'h0, lr[k]});
      wb(1, ctl, {24'h0, cr[k]});
      meas(32);
      `CHK("line", n_mk, 32)
      `CHK("looped", n_r1 == n_rx && n_rx > 24, 1'b1)
    end
  endtask
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    t_sources();
    t_alarm();
    t_lock();
    t_code();
    t_local();
    report_and_stop();
  end
endmodule
`default_nettype wire
